// file: core/ascb_consts.vh
`ifndef ASCB_CONSTS_VH
`define ASCB_CONSTS_VH

// Register indices; byte address is four times the index
`define ASCB_IDX_SETUP_CFG_0 8'h20
`define ASCB_IDX_SETUP_CFG_1 8'h21
`define ASCB_IDX_SETUP_CFG_2 8'h22
`define ASCB_IDX_SETUP_CFG_3 8'h23
// Read-only view of the coding and reference of the setup in use
`define ASCB_IDX_ACTIVE 8'h24

// Reset value of every setup register
`define ASCB_SETUP_RESET 16'h1020

// Field positions
`define ASCB_CODING_BIT 12
`define ASCB_REF_HI 5
`define ASCB_REF_LO 4
// Writable bits of a setup register
`define ASCB_SETUP_WMASK 16'h1030

// Reference source codes
`define ASCB_REF_EXT 2'h0
`define ASCB_REF_RSVD 2'h1
`define ASCB_REF_INT 2'h2
`define ASCB_REF_SUPPLY 2'h3

`endif

// file: core/ascb_setup_bank.v
`timescale 1ns/1ps
// Contract
// R1 - Four independent 16-bit setup registers at indices 0x20 to 0x23.
// R2 - Reset loads 0x1020 into every setup register.
// R3 - Bit 12 selects coding: 0 unipolar, 1 offset binary.
// R4 - Coding applies only to conversions using that setup.
// R5 - Bits 5:4 select reference: 00 external, 10 internal, 11 supply.
// R6 - Software must also enable the internal reference in mode register.
// R7 - Code 11 routes the analog supply difference as reference.
// R8 - Reserved bits are read-only zero; software writes zeros there.
// R9 - Software should not write reference code 01.
`include "ascb_consts.vh"

module ascb_setup_bank
(
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Avalon-MM slave
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Setup in use by the converter
    input wire [1:0] conv_setup,
    // Settings of the setup in use
    output reg coding_offset_binary,
    output reg [1:0] reference_source,
    output reg ref_use_external,
    output reg ref_use_internal,
    output reg ref_use_supply,
    output reg ref_code_invalid
);

    // Setup register contents
    wire [15:0] setup_q_0;
    wire [15:0] setup_q_1;
    wire [15:0] setup_q_2;
    wire [15:0] setup_q_3;
    // Per-setup fields
    wire coding_select_0;
    wire coding_select_1;
    wire coding_select_2;
    wire coding_select_3;
    wire [1:0] reference_source_0;
    wire [1:0] reference_source_1;
    wire [1:0] reference_source_2;
    wire [1:0] reference_source_3;
    // Bus side
    reg ack_ff;
    reg [31:0] nxt_rdata;
    reg [15:0] wbe;
    reg [3:0] wr_sel;
    wire [7:0] idx;
    wire req;
    wire hit;
    // Converter side
    reg nxt_coding;
    reg [1:0] nxt_ref;
    reg nxt_use_external;
    reg nxt_use_internal;
    reg nxt_use_supply;
    reg nxt_code_invalid;

    // One wait state on every access keeps read data a flop output
    assign idx = avs_address[9:2];
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_ff;
    assign hit = (idx[7:2] == 6'h08); // R1

    // Only lanes 0 and 1 carry register bits
    always @*
    begin
        wbe = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    end

    // Writes land at the edge where waitrequest is low
    always @*
    begin
        wr_sel = 4'h0;
        if (avs_write && ack_ff && hit)
        begin
            wr_sel = 4'h1 << idx[1:0]; // R1
        end
    end

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= req & ~ack_ff;
        end
    end

    ascb_setup_reg
    #(
        .RESET_VALUE(`ASCB_SETUP_RESET),
        .WRITE_MASK(`ASCB_SETUP_WMASK)
    )
    i_ascb_setup_reg_0
    (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_sel[0]),
        .wr_data(avs_writedata[15:0]),
        .wr_lanes(wbe),
        .q(setup_q_0)
    );

    ascb_setup_reg
    #(
        .RESET_VALUE(`ASCB_SETUP_RESET),
        .WRITE_MASK(`ASCB_SETUP_WMASK)
    )
    i_ascb_setup_reg_1
    (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_sel[1]),
        .wr_data(avs_writedata[15:0]),
        .wr_lanes(wbe),
        .q(setup_q_1)
    );

    ascb_setup_reg
    #(
        .RESET_VALUE(`ASCB_SETUP_RESET),
        .WRITE_MASK(`ASCB_SETUP_WMASK)
    )
    i_ascb_setup_reg_2
    (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_sel[2]),
        .wr_data(avs_writedata[15:0]),
        .wr_lanes(wbe),
        .q(setup_q_2)
    );

    ascb_setup_reg
    #(
        .RESET_VALUE(`ASCB_SETUP_RESET),
        .WRITE_MASK(`ASCB_SETUP_WMASK)
    )
    i_ascb_setup_reg_3
    (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_sel[3]),
        .wr_data(avs_writedata[15:0]),
        .wr_lanes(wbe),
        .q(setup_q_3)
    );

    // Field views of each setup
    assign coding_select_0 = setup_q_0[`ASCB_CODING_BIT]; // R3
    assign coding_select_1 = setup_q_1[`ASCB_CODING_BIT]; // R3
    assign coding_select_2 = setup_q_2[`ASCB_CODING_BIT]; // R3
    assign coding_select_3 = setup_q_3[`ASCB_CODING_BIT]; // R3
    assign reference_source_0 = setup_q_0[`ASCB_REF_HI:`ASCB_REF_LO]; // R5
    assign reference_source_1 = setup_q_1[`ASCB_REF_HI:`ASCB_REF_LO]; // R5
    assign reference_source_2 = setup_q_2[`ASCB_REF_HI:`ASCB_REF_LO]; // R5
    assign reference_source_3 = setup_q_3[`ASCB_REF_HI:`ASCB_REF_LO]; // R5

    // Unmapped indices read as zero, writes to them are ignored
    always @*
    begin
        case (idx)
            `ASCB_IDX_SETUP_CFG_0:
            begin
                nxt_rdata = {16'h0000, setup_q_0}; // R1 R8
            end
            `ASCB_IDX_SETUP_CFG_1:
            begin
                nxt_rdata = {16'h0000, setup_q_1}; // R1 R8
            end
            `ASCB_IDX_SETUP_CFG_2:
            begin
                nxt_rdata = {16'h0000, setup_q_2}; // R1 R8
            end
            `ASCB_IDX_SETUP_CFG_3:
            begin
                nxt_rdata = {16'h0000, setup_q_3}; // R1 R8
            end
            `ASCB_IDX_ACTIVE:
            begin
                nxt_rdata = {14'h0000, reference_source, 15'h0000,
                    coding_offset_binary};
            end
            default:
            begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data is captured in the wait cycle and stands until the next read
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && !ack_ff)
        begin
            avs_readdata <= nxt_rdata;
        end
    end

    // Only the setup in use steers the converter
    always @*
    begin
        case (conv_setup)
            2'h0:
            begin
                nxt_coding = coding_select_0; // R4
                nxt_ref = reference_source_0; // R4
            end
            2'h1:
            begin
                nxt_coding = coding_select_1; // R4
                nxt_ref = reference_source_1; // R4
            end
            2'h2:
            begin
                nxt_coding = coding_select_2; // R4
                nxt_ref = reference_source_2; // R4
            end
            default:
            begin
                nxt_coding = coding_select_3; // R4
                nxt_ref = reference_source_3; // R4
            end
        endcase
    end

    // One-hot routing of the selected reference
    always @*
    begin
        nxt_use_external = 1'b0;
        nxt_use_internal = 1'b0;
        nxt_use_supply = 1'b0;
        nxt_code_invalid = 1'b0;
        case (nxt_ref)
            `ASCB_REF_EXT:
            begin
                nxt_use_external = 1'b1; // R5
            end
            `ASCB_REF_INT:
            begin
                // Internal reference itself is powered from the mode register
                nxt_use_internal = 1'b1; // R5 R6
            end
            `ASCB_REF_SUPPLY:
            begin
                nxt_use_supply = 1'b1; // R7
            end
            default:
            begin
                // Code 01 is stored but routes nothing
                nxt_code_invalid = 1'b1; // R9
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            coding_offset_binary <= 1'b1; // R2
            reference_source <= `ASCB_REF_INT; // R2
            ref_use_external <= 1'b0;
            ref_use_internal <= 1'b1;
            ref_use_supply <= 1'b0;
            ref_code_invalid <= 1'b0;
        end
        else
        begin
            coding_offset_binary <= nxt_coding; // R3
            reference_source <= nxt_ref; // R5
            ref_use_external <= nxt_use_external; // R5
            ref_use_internal <= nxt_use_internal; // R5
            ref_use_supply <= nxt_use_supply; // R7
            ref_code_invalid <= nxt_code_invalid;
        end
    end

endmodule // ascb_setup_bank

// One setup register with per-lane writes and fixed reserved bits
module ascb_setup_reg
#(
    parameter WIDTH = 16,
    parameter RESET_VALUE = `ASCB_SETUP_RESET,
    parameter WRITE_MASK = `ASCB_SETUP_WMASK
)
(
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Write port
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    input wire [WIDTH-1:0] wr_lanes,
    // Stored value
    output reg [WIDTH-1:0] q
);

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            q <= RESET_VALUE; // R2
        end
        else if (wr_en)
        begin
            // Reserved bits stay zero regardless of write data
            q <= (q & ~wr_lanes) | (wr_data & wr_lanes & WRITE_MASK); // R8
        end
    end

endmodule // ascb_setup_reg

// file: test/ascb_setup_bank_monitor.sv
`timescale 1ns/1ps
module ascb_mon
(
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Register bus
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire [9:0] avs_address,
    input wire [31:0] avs_readdata,
    // Converter side
    input wire [1:0] conv_setup,
    input wire coding_offset_binary,
    input wire [1:0] reference_source,
    input wire ref_use_external,
    input wire ref_use_internal,
    input wire ref_use_supply,
    input wire ref_code_invalid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire t;
    assign t = avs_read && !avs_waitrequest && avs_address[9:4] == 6'h08;
    property p_r; $rose(rstn) |-> reference_source == 2'h2; endproperty
    a_r: assert property (p_r) else $error("reset");
    property p_w; $rose(avs_read) |-> avs_waitrequest ##1
        !avs_waitrequest; endproperty
    a_w: assert property (p_w) else $error("wait");
    property p_v; t |-> !(avs_readdata & 32'hffffefcf); endproperty
    a_v: assert property (p_v) else $error("reserved");
    property p_c; t && $stable(conv_setup) && avs_address[3:2] ==
        conv_setup |-> avs_readdata[12] == coding_offset_binary;
    endproperty
    a_c: assert property (p_c) else $error("coding");
    property p_b; $rose(rstn) |-> coding_offset_binary && ref_use_internal;
    endproperty
    a_b: assert property (p_b) else $error("reset coding");
    property p_i; !avs_read && !avs_write |-> !avs_waitrequest; endproperty
    a_i: assert property (p_i) else $error("idle wait");
    property p_h; $onehot({ref_use_external, ref_use_internal,
        ref_use_supply, ref_code_invalid}); endproperty
    a_h: assert property (p_h) else $error("routing");
    property p_s; ref_use_supply == (reference_source == 2'h3); endproperty
    a_s: assert property (p_s) else $error("supply");
    cover property (t);
    cover property ($rose(rstn));
    cover property (reference_source == 2'h3);
endmodule // ascb_mon

// file: test/ascb_setup_bank_test.sv
`timescale 1ns/1ps
module ascb_setup_bank_test;
    logic clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
    logic avs_waitrequest, coding_offset_binary, ref_use_external;
    logic ref_use_internal, ref_use_supply, ref_code_invalid;
    logic [9:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q, k, e;
    logic [3:0] avs_byteenable = 4'hf, be;
    logic [1:0] conv_setup = 0, reference_source, r;
    logic [15:0] m [4] = '{4{16'h1020}};
    logic [15:0] w;
    int failures = 0, tests_run = 0, i, n, cs = 0;
    ascb_setup_bank i_ascb_setup_bank(
        .clk(clk),
        .rstn(rstn),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .conv_setup(conv_setup),
        .coding_offset_binary(coding_offset_binary),
        .reference_source(reference_source),
        .ref_use_external(ref_use_external),
        .ref_use_internal(ref_use_internal),
        .ref_use_supply(ref_use_supply),
        .ref_code_invalid(ref_code_invalid)
    );
    initial forever #2.5 clk = ~clk;
    // Tests take about 600 cycles; the limit leaves ample margin
    initial #9000 give_verdict(1);
    task check(input logic [31:0] got, exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    // Outputs are registered, so look at them mid-cycle once settled
    task outs;
        @(negedge clk);
        r = m[cs][5:4];
        check(coding_offset_binary, m[cs][12], "coding");
        check(reference_source, r, "reference");
        check(ref_use_external, r == 2'h0, "external");
        check(ref_use_internal, r == 2'h2, "internal");
        check(ref_use_supply, r == 2'h3, "supply");
        check(ref_code_invalid, r == 2'h1, "code 01");
        @(posedge clk);
    endtask
    task acc(input logic v);
        {avs_read, avs_write} <= {!v, v};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_read, avs_write} <= 2'h0;
        @(posedge clk);
    endtask
    task give_verdict(input int n);
        failures += n;
        $display("%0d/%0d wrong", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(54511));
        repeat (6) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        outs;
        for (n = 0; n < 80; n++)
        begin
            if (n == 40)
            begin
                rstn <= 0;
                repeat (2) @(posedge clk);
                rstn <= 1;
                m = '{4{16'h1020}};
                @(posedge clk);
                outs;
            end
            i = $urandom % 6;
            avs_address <= i < 4 ? 10'(128 + 4 * i)
                : (i == 4 ? 10'h3fc : 10'h090);
            e = i < 4 ? {16'h0, m[i]} : 32'h0;
            if (i == 5) e = {14'h0, m[cs][5:4], 15'h0, m[cs][12]};
            acc(0);
            check(q, e, "readback");
            k = $urandom;
            if (k[5:4] == 2'h1) k[4] = 1'b0;
            be = 4'($urandom);
            avs_writedata <= k;
            avs_byteenable <= be;
            cs = $urandom % 4;
            conv_setup <= 2'(cs);
            acc(1);
            if (i < 4)
            begin
                w = m[i];
                if (be[0]) w[7:0] = k[7:0];
                if (be[1]) w[15:8] = k[15:8];
                m[i] = w & 16'h1030;
            end
            outs;
        end
        $display("test done");
        give_verdict(0);
    end
endmodule // ascb_setup_bank_test
bind ascb_setup_bank ascb_mon i_ascb_mon(
    .clk(clk),
    .rstn(rstn),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest),
    .avs_address(avs_address),
    .avs_readdata(avs_readdata),
    .conv_setup(conv_setup),
    .coding_offset_binary(coding_offset_binary),
    .reference_source(reference_source),
    .ref_use_external(ref_use_external),
    .ref_use_internal(ref_use_internal),
    .ref_use_supply(ref_use_supply),
    .ref_code_invalid(ref_code_invalid)
);
